// ===== alarm_irq_pkg.sv
// Purpose: shared constants of the alarm interrupt aggregator
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   register byte address is four times its index
package alarm_irq_pkg;

   localparam int unsigned ADDR_W = 12;
   localparam int unsigned IDX_W  = 10;
   localparam int unsigned REG_W  = 8;

   // register indices; byte address = 4 * index
   localparam logic [9:0] IDX_LIVE_INPUT  = 10'h00d;
   localparam logic [9:0] IDX_LIVE_LOOP   = 10'h00e;
   localparam logic [9:0] IDX_FLAG_XTAL   = 10'h011;
   localparam logic [9:0] IDX_FLAG_INPUT  = 10'h012;
   localparam logic [9:0] IDX_FLAG_LOOP   = 10'h013;
   localparam logic [9:0] IDX_MASK_XTAL   = 10'h017;
   localparam logic [9:0] IDX_MASK_INPUT  = 10'h018;
   localparam logic [9:0] IDX_MASK_LOOP   = 10'h019;

   // field positions inside the 8-bit registers
   localparam int unsigned LOS_LSB  = 0;
   localparam int unsigned OOF_LSB  = 4;
   localparam int unsigned XTAL_BIT = 1;
   localparam int unsigned LOL_LSB  = 0;
   localparam int unsigned HOLD_LSB = 4;

   // positions in the packed source vector
   localparam int unsigned SRC_INPUT = 0;
   localparam int unsigned SRC_XTAL  = 8;
   localparam int unsigned SRC_LOOP  = 9;
   localparam int unsigned N_SRC     = 17;

   // reset values
   localparam logic [7:0] MASK_RST = 8'hff;
   localparam logic [7:0] FLAG_RST = 8'h00;

endpackage

// ===== sticky_flag_bank.sv
// Purpose: bank of sticky alarm flags, set on alarm rise
// Assumes: alarms are synchronous to pclk
// Notes:   a clear request is refused while its alarm is active
`timescale 1ns/100ps
`default_nettype none
module sticky_flag_bank #(
   parameter int unsigned WIDTH = 17
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] alarm,
   input  wire logic [WIDTH-1:0] clr_req,
   output var  logic [WIDTH-1:0] flag
);

   logic [WIDTH-1:0] alarm_prev;
   logic [WIDTH-1:0] rise;
   logic [WIDTH-1:0] clr_ok;

   assign rise   = alarm & ~alarm_prev;
   // an active alarm blocks its own clear
   assign clr_ok = clr_req & ~alarm;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alarm_prev <= '0;
      end else begin
         alarm_prev <= alarm;
      end
   end

   // set wins over clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag <= '0;
      end else begin
         flag <= (flag & ~clr_ok) | rise;
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_rise_sets_flag: assert property (
      (rise != 0) |=> ((flag & $past(rise)) == $past(rise)))
      else $error("alarm rise did not set its flag");

   a_flag_stays_set: assert property (
      (flag != 0) |=> ((flag & $past(flag & ~clr_req)) == $past(flag & ~clr_req)))
      else $error("flag dropped without a clear request");

   a_active_blocks_clr: assert property (
      (flag & alarm) != 0 |=> ((flag & $past(flag & alarm)) == $past(flag & alarm)))
      else $error("flag cleared while its alarm was active");

   a_idle_clr_works: assert property (
      (clr_req & ~alarm & alarm_prev) == '0 && (clr_req & ~alarm) != 0
      |=> ((flag & $past(clr_req & ~alarm)) == '0))
      else $error("clear request on idle alarm was not honoured");

endmodule
`default_nettype wire

// ===== alarm_interrupt_aggregator.sv
// Purpose: sticky alarm flags, masks and an active-low interrupt pin
// Assumes: APB slave on pclk; alarm inputs synchronous to pclk
// Notes:   pready rises one cycle into the access phase
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module alarm_interrupt_aggregator
(
   input  wire logic                             pclk,
   input  wire logic                             presetn,
   input  wire logic                             psel,
   input  wire logic                             penable,
   input  wire logic                             pwrite,
   input  wire logic [alarm_irq_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                      pwdata,
   input  wire logic [3:0]                       pstrb,
   output var  logic [31:0]                      prdata,
   output var  logic                             pready,
   output var  logic                             pslverr,
   input  wire logic [3:0]                       signal_loss_alarm,
   input  wire logic [3:0]                       freq_offset_alarm,
   input  wire logic                             crystal_loss_alarm,
   input  wire logic [3:0]                       lock_loss_alarm,
   input  wire logic [3:0]                       holdover_alarm,
   output var  logic                             irq_out_n
);
   import alarm_irq_pkg::*;

   logic [REG_W-1:0] crystal_alarm_irq_mask;
   logic [REG_W-1:0] input_alarm_irq_mask;
   logic [REG_W-1:0] loop_alarm_irq_mask;
   logic [N_SRC-1:0] alarm_vec;
   logic [N_SRC-1:0] sticky_alarm_flag;
   logic [N_SRC-1:0] clr_req;
   logic [N_SRC-1:0] irq_mask_bit;
   logic [N_SRC-1:0] pending;
   logic [IDX_W-1:0] idx;
   logic             access;
   logic             wr_take;
   logic             lane0;
   logic             bad_addr;
   logic [REG_W-1:0] rd_val;

   function automatic logic known_idx(input logic [IDX_W-1:0] i);
      return i inside {IDX_LIVE_INPUT, IDX_LIVE_LOOP, IDX_FLAG_XTAL,
                       IDX_FLAG_INPUT, IDX_FLAG_LOOP, IDX_MASK_XTAL,
                       IDX_MASK_INPUT, IDX_MASK_LOOP};
   endfunction

   function automatic logic wr_to(input logic [IDX_W-1:0] i,
                                  input logic [IDX_W-1:0] target,
                                  input logic             take);
      return take && (i == target);
   endfunction

   assign idx      = paddr[ADDR_W-1:2];
   assign access   = psel & penable;
   assign lane0    = pstrb[0];
   // writes land only at the completing edge and only on byte lane 0
   assign wr_take  = access & pready & pwrite & lane0 & ~pslverr;
   assign bad_addr = ~known_idx(idx) | (paddr[1:0] != 2'h0);

   assign alarm_vec = {holdover_alarm, lock_loss_alarm,
                       crystal_loss_alarm,
                       freq_offset_alarm, signal_loss_alarm};

   assign irq_mask_bit = {loop_alarm_irq_mask,
                          crystal_alarm_irq_mask[XTAL_BIT],
                          input_alarm_irq_mask};

   assign pending = sticky_alarm_flag & ~irq_mask_bit;

   // a zero bit in the written data asks for a clear; a one is ignored
   always_comb begin
      clr_req = '0;
      if (wr_to(idx, IDX_FLAG_INPUT, wr_take)) begin
         clr_req[SRC_INPUT +: REG_W] = ~pwdata[REG_W-1:0];
      end
      if (wr_to(idx, IDX_FLAG_XTAL, wr_take)) begin
         clr_req[SRC_XTAL] = ~pwdata[XTAL_BIT];
      end
      if (wr_to(idx, IDX_FLAG_LOOP, wr_take)) begin
         clr_req[SRC_LOOP +: REG_W] = ~pwdata[REG_W-1:0];
      end
   end

   sticky_flag_bank #(
      .WIDTH (N_SRC)
   ) u_flags (
      .pclk    (pclk),
      .presetn (presetn),
      .alarm   (alarm_vec),
      .clr_req (clr_req),
      .flag    (sticky_alarm_flag)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crystal_alarm_irq_mask <= MASK_RST;
      end else if (wr_to(idx, IDX_MASK_XTAL, wr_take)) begin
         crystal_alarm_irq_mask <= pwdata[REG_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         input_alarm_irq_mask <= MASK_RST;
      end else if (wr_to(idx, IDX_MASK_INPUT, wr_take)) begin
         input_alarm_irq_mask <= pwdata[REG_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loop_alarm_irq_mask <= MASK_RST;
      end else if (wr_to(idx, IDX_MASK_LOOP, wr_take)) begin
         loop_alarm_irq_mask <= pwdata[REG_W-1:0];
      end
   end

   // pin is registered, so it trails the flags by one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_out_n <= 1'b1;
      end else begin
         irq_out_n <= ~|pending;
      end
   end

   always_comb begin
      rd_val = FLAG_RST;
      unique case (idx)
         IDX_LIVE_INPUT: begin
            rd_val = {freq_offset_alarm, signal_loss_alarm};
         end
         IDX_LIVE_LOOP: begin
            rd_val = {holdover_alarm, lock_loss_alarm};
         end
         IDX_FLAG_XTAL: begin
            rd_val[XTAL_BIT] = sticky_alarm_flag[SRC_XTAL];
         end
         IDX_FLAG_INPUT: begin
            rd_val = sticky_alarm_flag[SRC_INPUT +: REG_W];
         end
         IDX_FLAG_LOOP: begin
            rd_val = sticky_alarm_flag[SRC_LOOP +: REG_W];
         end
         IDX_MASK_XTAL: begin
            rd_val = crystal_alarm_irq_mask;
         end
         IDX_MASK_INPUT: begin
            rd_val = input_alarm_irq_mask;
         end
         IDX_MASK_LOOP: begin
            rd_val = loop_alarm_irq_mask;
         end
         default: begin
            rd_val = FLAG_RST;
         end
      endcase
   end

   // one wait state keeps read data and the error flag registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= access & ~pready;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= access & ~pready & bad_addr;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (access & ~pready & ~pwrite & ~bad_addr) begin
         prdata <= {24'h00_0000, rd_val};
      end else begin
         prdata <= 32'h0000_0000;
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_irq_asserts: assert property (
      (pending != 0) |=> !irq_out_n)
      else $error("unmasked flag did not pull the interrupt low");

   a_irq_releases: assert property (
      (pending == 0) |=> irq_out_n)
      else $error("interrupt low with no unmasked flag");

   a_input_los_mask: assert property (
      (sticky_alarm_flag == 17'h0_000f) && (input_alarm_irq_mask[3:0] == 4'hf)
      |=> irq_out_n)
      else $error("signal-loss mask did not block the interrupt");

   a_input_oof_mask: assert property (
      (sticky_alarm_flag == 17'h0_00f0) && (input_alarm_irq_mask[7:4] != 4'hf)
      |=> !irq_out_n)
      else $error("unmasked offset flag did not interrupt");

   a_xtal_mask: assert property (
      (sticky_alarm_flag == 17'h0_0100)
      |=> (irq_out_n == $past(crystal_alarm_irq_mask[XTAL_BIT])))
      else $error("crystal mask bit not honoured");

   a_loop_mask: assert property (
      (sticky_alarm_flag[SRC_XTAL:0] == '0)
      |=> (irq_out_n == $past((sticky_alarm_flag[N_SRC-1:SRC_LOOP]
                               & ~loop_alarm_irq_mask) == 8'h00)))
      else $error("loop flags and masks disagree with the pin");

   a_clear_releases: assert property (
      wr_to(idx, IDX_FLAG_INPUT, wr_take) && (pwdata[7:0] == 8'h00)
      && (sticky_alarm_flag == 17'h0_0001) && (alarm_vec == '0)
      |=> ##1 irq_out_n)
      else $error("clearing the only flag left the interrupt low");

   a_ready_timing: assert property (
      access && !pready |=> pready ##1 !pready)
      else $error("pready not a single cycle after the first access cycle");

   c_irq_raised: cover property (
      $rose(alarm_vec[SRC_INPUT]) ##[1:4] $fell(irq_out_n));

   c_clear_refused: cover property (
      clr_req[SRC_LOOP] && alarm_vec[SRC_LOOP] ##1 sticky_alarm_flag[SRC_LOOP]);

   c_irq_cleared: cover property (
      !irq_out_n ##1 (clr_req != 0) ##[1:3] irq_out_n);

endmodule
`default_nettype wire

// ===== host_model.sv
// Purpose: host model, APB master with a task that reads flags and masks to find pending sources
// Assumes: one transfer at a time, started after a rising edge
// Notes:   released address and data lines show the inverse of the last value
`timescale 1ns/100ps
`default_nettype none
module host_model (
   input  wire logic        pclk,
   output var  logic        psel,
   output var  logic        penable,
   output var  logic        pwrite,
   output var  logic [11:0] paddr,
   output var  logic [31:0] pwdata,
   output var  logic [3:0]  pstrb,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire logic        irq_out_n
);
   // byte strobes of the next transfer; the bench may drop lane 0 to test a refused write
   logic [3:0] strb = 4'hf;

   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0000_0000;
      pstrb   = 4'h0;
   end

   // clearing a flag is a write of zero to its bit
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= strb;
      @(posedge pclk);
      penable <= 1'b1;
      // no cycle count assumed: the wait ends when pready is seen high, or at the bench timeout
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      paddr   <= ~a;
      pwdata  <= ~d;
   endtask

   // active sources are the flags and-ed with the inverted masks
   task automatic pending(input logic [11:0] fa, input logic [11:0] ma,
                          output logic [7:0] p);
      logic [31:0] f;
      logic [31:0] m;
      logic        e;
      xfer(1'b0, fa, 32'h0000_0000, f, e);
      xfer(1'b0, ma, 32'h0000_0000, m, e);
      p = f[7:0] & ~m[7:0];
   endtask
endmodule
`default_nettype wire

// ===== alarm_interrupt_aggregator_tb.sv
// Purpose: self-checking bench of the alarm interrupt aggregator
// Assumes: alarms driven synchronously to pclk
// Notes:   pin checks wait three edges, the flag-to-pin lag plus margin
`timescale 1ns/100ps
`default_nettype none
module alarm_interrupt_aggregator_tb;
   import alarm_irq_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_out_n, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb;
   logic [16:0] src;
   logic [7:0]  p;
   int          bad_count, checked, cyc;

   alarm_interrupt_aggregator alarm_interrupt_aggregator_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .signal_loss_alarm(src[3:0]), .freq_offset_alarm(src[7:4]),
      .crystal_loss_alarm(src[8]), .lock_loss_alarm(src[12:9]),
      .holdover_alarm(src[16:13]), .irq_out_n(irq_out_n));

   host_model host_model_inst (
      .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq_out_n(irq_out_n));

   always #10 pclk = ~pclk;

   task automatic test_done;
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         test_done();
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
      host_model_inst.xfer(1'b0, {idx, 2'b00}, 32'h0000_0000, rd, er);
      check("read data", rd, exp);
   endtask

   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      host_model_inst.xfer(1'b1, {idx, 2'b00}, {24'h00_0000, d}, rd, er);
   endtask

   task automatic irq_chk(input logic exp);
      repeat (3) @(posedge pclk);
      check("irq_out_n", {31'h0000_0000, irq_out_n}, {31'h0000_0000, exp});
   endtask

   // source order: los[3:0], oof[3:0], crystal, lol[3:0], hold[3:0]
   function automatic logic [9:0] fidx(input int i);
      return i < 8 ? IDX_FLAG_INPUT : (i == 8 ? IDX_FLAG_XTAL : IDX_FLAG_LOOP);
   endfunction
   function automatic logic [9:0] midx(input int i);
      return i < 8 ? IDX_MASK_INPUT : (i == 8 ? IDX_MASK_XTAL : IDX_MASK_LOOP);
   endfunction
   function automatic logic [7:0] fbit(input int i);
      return i < 8 ? 8'h01 << i : (i == 8 ? 8'h02 : 8'h01 << (i - 9));
   endfunction

   initial begin
      pclk      = 1'b0;
      presetn   = 1'b0;
      src       = 17'h0_0000;
      bad_count = 0;
      checked   = 0;
      cyc       = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(IDX_MASK_XTAL, 32'h0000_00ff);
      rd_chk(IDX_MASK_INPUT, 32'h0000_00ff);
      rd_chk(IDX_MASK_LOOP, 32'h0000_00ff);
      rd_chk(IDX_FLAG_INPUT, 32'h0000_0000);
      irq_chk(1'b1);
      // each source alone: masked pulse, then unmask, then clear
      for (int i = 0; i < 17; i++) begin
         @(posedge pclk);
         src[i] <= 1'b1;
         @(posedge pclk);
         src[i] <= 1'b0;
         irq_chk(1'b1);
         rd_chk(fidx(i), {24'h00_0000, fbit(i)});
         wr(midx(i), ~fbit(i));
         irq_chk(1'b0);
         wr(fidx(i), 8'hff);
         rd_chk(fidx(i), {24'h00_0000, fbit(i)});
         wr(fidx(i), ~fbit(i));
         irq_chk(1'b1);
         rd_chk(fidx(i), 32'h0000_0000);
         wr(midx(i), 8'hff);
      end
      // clear refused while the alarm stays high
      @(posedge pclk);
      src[9] <= 1'b1;
      wr(IDX_MASK_LOOP, 8'hfe);
      wr(IDX_FLAG_LOOP, 8'h00);
      rd_chk(IDX_FLAG_LOOP, 32'h0000_0001);
      rd_chk(IDX_LIVE_LOOP, 32'h0000_0001);
      host_model_inst.strb = 4'he;
      wr(IDX_MASK_LOOP, 8'h00);
      host_model_inst.strb = 4'hf;
      rd_chk(IDX_MASK_LOOP, 32'h0000_00fe);
      irq_chk(1'b0);
      // two pending sources, released one at a time
      @(posedge pclk);
      src[9] <= 1'b0;
      src[0] <= 1'b1;
      @(posedge pclk);
      src[0] <= 1'b0;
      wr(IDX_MASK_INPUT, 8'hfe);
      host_model_inst.pending({IDX_FLAG_INPUT, 2'b00}, {IDX_MASK_INPUT, 2'b00}, p);
      check("pending", {24'h00_0000, p}, 32'h0000_0001);
      wr(IDX_FLAG_LOOP, 8'h00);
      irq_chk(1'b0);
      wr(IDX_FLAG_INPUT, 8'h00);
      irq_chk(1'b1);
      host_model_inst.xfer(1'b0, 12'h0fc, 32'h0000_0000, rd, er);
      check("unmapped error", {31'h0000_0000, er}, 32'h0000_0001);
      check("unmapped data", rd, 32'h0000_0000);
      test_done();
   end
endmodule
`default_nettype wire
